// ---- pkg/sfdps_pkg.sv ----
// constants, types and helpers for the deep sleep sequencer
package sfdps_pkg;

  // instruction bytes seen on the link
  localparam logic [7:0] OP_SLEEP_ENTRY = 8'hB9;
  localparam logic [7:0] OP_SLEEP_RELEASE = 8'hAB;

  // serial clock edges per instruction byte in each mode
  localparam int SERIAL_EDGES = 8;
  localparam int QUAD_EDGES = 2;
  localparam int QUAD_LANES = 4;
  localparam int EDGE_CNT_W = 4;
  localparam logic [EDGE_CNT_W-1:0] EDGE_CNT_MAX = 4'hF;
  localparam logic [EDGE_CNT_W-1:0] EDGE_CNT_FIRST = 4'h1;

  // system clock period and the two delays, in their own units
  localparam int MCLK_PERIOD_PS = 10000;
  localparam int SLEEP_ENTRY_DELAY_NS = 3000;
  localparam int SLEEP_RELEASE_DELAY_NS = 3000;

  // longest time: round down, never below one cycle
  function automatic int ns_to_cycles_floor(input int ns);
    int c;
    c = (ns * 1000) / MCLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // least time: round up, never below one cycle
  function automatic int ns_to_cycles_ceil(input int ns);
    int c;
    c = (ns * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int SLEEP_ENTRY_CYCLES =
    ns_to_cycles_floor(SLEEP_ENTRY_DELAY_NS);
  localparam int SLEEP_RELEASE_CYCLES =
    ns_to_cycles_ceil(SLEEP_RELEASE_DELAY_NS);
  localparam int DELAY_CNT_W = 16;

  // reset values of the synchroniser stages
  localparam logic SELECT_IDLE = 1'b1;

  // power sequencing states
  typedef enum logic [1:0] {
    SFDPS_STANDBY,
    SFDPS_ENTERING,
    SFDPS_SLEEP,
    SFDPS_RELEASING
  } sfdps_state_t;

  // what the link side captured during the last frame
  typedef struct packed {
    logic [7:0] serial_byte;
    logic [7:0] quad_byte;
    logic [EDGE_CNT_W-1:0] edges;
  } sfdps_capture_t;

  localparam sfdps_capture_t CAPTURE_RESET = '0;

endpackage

// ---- testbench/sfdps_host_model.sv ----
// host controller model driving select, link clock and data
`timescale 1ns/1ps
module sfdps_host_model (
  output logic sclk,
  output logic cs_n,
  output logic [3:0] dq
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    dq = 4'h5;
  end

  // one frame of n clock rises; link clock still outside frames
  task automatic frame(input logic [7:0] op, input logic q, input int n);
    logic [7:0] sh;
    sh = op;
    #37 cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (q) begin
        dq = sh[7:4];
        sh = {sh[3:0], 4'h0};
      end else begin
        dq = {3'h0, sh[7]};
        sh = {sh[6:0], 1'b0};
      end
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
    end
    // select rises right after the last bit and stays high after
    #30 cs_n = 1'b1;
    dq = ~dq;
  endtask
endmodule

// ---- testbench/sfdps_props.sv ----
// port assertions for the deep sleep sequencer
`timescale 1ns/1ps
module sfdps_props #(
  parameter int ENTRY_CYCLES = 5,
  parameter int RELEASE_CYCLES = 5
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic embedded_op_active,
  input wire logic [sfdps_pkg::QUAD_LANES-1:0] quad_data_lines_oe,
  input wire logic deep_sleep,
  input wire logic cmd_accept,
  input wire logic entry_taken,
  input wire logic entry_refused,
  input wire logic cmd_ignored,
  input wire logic release_done
);
  // slack covers the one cycle lag of the level flags
  localparam int EMAX = ENTRY_CYCLES + 4;
  localparam int RMAX = RELEASE_CYCLES + 4;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // the lines are never driven, not even on release
  no_drive_a: assert property (quad_data_lines_oe == 4'h0)
    else $error("data lines driven");
  idle_entry_a: assert property (entry_taken |-> !$past(embedded_op_active))
    else $error("entry taken while busy");
  refuse_keeps_a: assert property (entry_refused |->
    (cmd_accept && !deep_sleep) [*8])
    else $error("refused entry changed state");
  entry_time_a: assert property (entry_taken |-> ##[1:EMAX] deep_sleep)
    else $error("sleep not reached in time");
  sleep_deaf_a: assert property (deep_sleep |-> !cmd_accept)
    else $error("commands accepted while asleep");
  ignored_stays_a: assert property (cmd_ignored && deep_sleep |=>
    deep_sleep [*4])
    else $error("ignored frame woke the device");
  // ready follows the release pulse by one cycle, as both are registered
  ready_cause_a: assert property ($rose(cmd_accept) |-> $past(release_done))
    else $error("ready without release wait");
  wake_time_a: assert property ($fell(deep_sleep) |->
    ##[1:RMAX] release_done)
    else $error("release wait too long");
  reset_idle_a: assert property ($rose(rst_n) |->
    cmd_accept && !deep_sleep)
    else $error("not in standby after reset");

  cover property (entry_taken);
  cover property (release_done);
  cover property (entry_refused);
endmodule

// ---- testbench/test_sfdps_top.sv ----
// self-checking bench for the deep sleep sequencer
`timescale 1ns/1ps
module test_sfdps_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic qm = 1'b0;
  logic busy = 1'b0;
  logic sclk, cs_n, deep_sleep, cmd_accept;
  logic tk, rf, bl, ig, rd;
  logic [3:0] dq, oe, dout;
  logic [4:0] seen = 5'h00;
  int bad_count = 0;
  int total_checks = 0;
  wire logic [6:0] st = {seen, deep_sleep, cmd_accept};

  always #5 mclk = ~mclk;
  // pulses last one cycle, so gather them over a frame
  always @(posedge mclk) seen <= seen | {tk, rf, bl, ig, rd};

  sfdps_host_model i_sfdps_host_model (.sclk(sclk), .cs_n(cs_n), .dq(dq));
  sfdps_top #(.ENTRY_CYCLES(5), .RELEASE_CYCLES(5)) i_sfdps_top (
    .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
    .quad_data_lines_in(dq), .quad_data_lines_out(dout),
    .quad_data_lines_oe(oe), .quad_instruction_mode(qm),
    .embedded_op_active(busy), .deep_sleep(deep_sleep),
    .cmd_accept(cmd_accept), .entry_taken(tk), .entry_refused(rf),
    .entry_bad_length(bl), .cmd_ignored(ig), .release_done(rd));

  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset;
    rst_n = 1'b0;
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    seen = 5'h00;
    @(negedge mclk);
  endtask

  // one frame, then select held high well past either delay
  task automatic frm(input logic [7:0] op, input int n);
    @(negedge mclk) seen = 5'h00;
    i_sfdps_host_model.frame(op, qm, n);
    repeat (20) @(negedge mclk);
  endtask

  task automatic t_busy;
    @(negedge mclk) busy = 1'b1;
    frm(8'hB9, 8);
    chk(st, 7'h21);
    @(negedge mclk) busy = 1'b0;
  endtask

  task automatic t_length;
    frm(8'hB9, 7);
    chk(st, 7'h01);
    frm(8'hB9, 9);
    chk(st, 7'h11);
  endtask

  task automatic t_serial;
    frm(8'hB9, 8);
    chk(st, 7'h42);
    frm(8'h05, 8);
    chk(st, 7'h0A);
    frm(8'hB9, 8);
    chk(st, 7'h0A);
    frm(8'hAB, 8);
    chk(st, 7'h05);
    chk({3'h0, oe}, 7'h00);
    chk({3'h0, dout}, 7'h00);
  endtask

  task automatic t_quad;
    @(negedge mclk) qm = 1'b1;
    frm(8'hB9, 2);
    chk(st, 7'h42);
    frm(8'hAB, 2);
    chk(st, 7'h05);
    chk({3'h0, oe}, 7'h00);
    chk({3'h0, dout}, 7'h00);
    @(negedge mclk) qm = 1'b0;
  endtask

  task automatic t_hwreset;
    frm(8'hB9, 8);
    chk(st, 7'h42);
    do_reset();
    chk(st, 7'h01);
  endtask

  initial begin
    do_reset();
    chk(st, 7'h01);
    t_busy();
    t_length();
    t_serial();
    t_quad();
    t_hwreset();
    finish_test();
  end

  // whole run is about 12 us of frames
  initial begin
    #100us;
    bad_count++;
    finish_test();
  end
endmodule

bind sfdps_top sfdps_props #(
  .ENTRY_CYCLES(ENTRY_CYCLES),
  .RELEASE_CYCLES(RELEASE_CYCLES)
) i_sfdps_props (
  .mclk, .rst_n, .embedded_op_active, .quad_data_lines_oe, .deep_sleep,
  .cmd_accept, .entry_taken, .entry_refused, .cmd_ignored, .release_done);

// ---- verilog/sfdps_sync.sv ----
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sfdps_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// ---- verilog/sfdps_top.sv ----
// deep sleep entry and release sequencer of a serial flash
//
// How it works
// R01 - entry instruction taken only while the embedded operation flag is 0
// R02 - host opens entry with select low and shifts in the entry byte
// R03 - select must rise right after the eighth bit, else no entry
// R04 - after a valid entry the sleep state is reached within entry delay
// R05 - while asleep only the release instruction counts, all else ignored
// R06 - power-up always lands in standby, never in sleep
// R07 - quad mode carries both instructions on four lines, two clocks each
// R08 - host leaves sleep with select low, release byte, select high
// R09 - after release wait the release delay before accepting commands
// R10 - host keeps select high during the whole release delay
// R11 - release instruction returns no identification data
// R12 - hardware reset also takes the device out of sleep
// R13 - a refused entry leaves the running operation and normal mode alone
`timescale 1ns/1ps
module sfdps_top #(
  parameter int ENTRY_CYCLES = sfdps_pkg::SLEEP_ENTRY_CYCLES,
  parameter int RELEASE_CYCLES = sfdps_pkg::SLEEP_RELEASE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [sfdps_pkg::QUAD_LANES-1:0] quad_data_lines_in,
  output logic [sfdps_pkg::QUAD_LANES-1:0] quad_data_lines_out,
  output logic [sfdps_pkg::QUAD_LANES-1:0] quad_data_lines_oe,
  input wire logic quad_instruction_mode,
  input wire logic embedded_op_active,
  output logic deep_sleep,
  output logic cmd_accept,
  output logic entry_taken,
  output logic entry_refused,
  output logic entry_bad_length,
  output logic cmd_ignored,
  output logic release_done
);

  localparam int CW = sfdps_pkg::DELAY_CNT_W;

  // ------------------------------------------------------------------
  // link side, clocked by the serial clock
  // ------------------------------------------------------------------

  logic frame_fresh_r;
  logic link_async_set;
  sfdps_pkg::sfdps_capture_t link_cap_r;

  // select high marks the next edge as the first of a frame; the
  // serial clock stands still outside frames, so this is set
  // asynchronously rather than by an edge that may never come
  assign link_async_set = cs_n | ~rst_n;

  always_ff @(posedge sclk or posedge link_async_set) begin
    if (link_async_set) begin
      frame_fresh_r <= 1'b1;
    end else begin
      frame_fresh_r <= 1'b0;
    end
  end

  // shift both the one-line and the four-line view of the byte, so
  // the link never needs the mode; the decoder picks one later
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      link_cap_r <= sfdps_pkg::CAPTURE_RESET;
    end else if (!cs_n) begin
      if (frame_fresh_r) begin
        link_cap_r.serial_byte <= {7'h00, quad_data_lines_in[0]};
        link_cap_r.quad_byte <= {4'h0, quad_data_lines_in}; // R07
        link_cap_r.edges <= sfdps_pkg::EDGE_CNT_FIRST;
      end else begin
        link_cap_r.serial_byte <=
          {link_cap_r.serial_byte[6:0], quad_data_lines_in[0]};
        link_cap_r.quad_byte <=
          {link_cap_r.quad_byte[3:0], quad_data_lines_in}; // R07
        // saturate so an over-long frame never wraps back to a match
        if (link_cap_r.edges != sfdps_pkg::EDGE_CNT_MAX) begin
          link_cap_r.edges <= link_cap_r.edges + 1'b1; // R03
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // crossing: select is synchronised; the capture is read only once
  // the synchronised select has risen, when the serial clock is idle
  // and the capture is therefore stable
  // ------------------------------------------------------------------

  logic cs_n_sync;
  logic cs_n_prev_r;
  logic frame_end;
  logic frame_start;

  sfdps_sync #(
    .WIDTH(1),
    .RESET_VAL(sfdps_pkg::SELECT_IDLE)
  ) u_cs_sync (
    .clk(mclk),
    .rst_n(rst_n),
    .d(cs_n),
    .q(cs_n_sync)
  );

  // edge detect on the synchronised select only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_prev_r <= sfdps_pkg::SELECT_IDLE;
    end else begin
      cs_n_prev_r <= cs_n_sync;
    end
  end

  assign frame_end = cs_n_sync & ~cs_n_prev_r;
  assign frame_start = ~cs_n_sync & cs_n_prev_r;

  // ------------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------------

  // byte length is exact: eight edges serial, two edges quad
  function automatic logic frame_len_ok(
    input sfdps_pkg::sfdps_capture_t cap,
    input logic quad
  );
    logic ok;
    if (quad) begin
      ok = (cap.edges == sfdps_pkg::EDGE_CNT_W'(sfdps_pkg::QUAD_EDGES));
    end else begin
      ok = (cap.edges == sfdps_pkg::EDGE_CNT_W'(sfdps_pkg::SERIAL_EDGES));
    end
    return ok;
  endfunction

  // instruction byte as seen in the current mode
  function automatic logic [7:0] frame_byte(
    input sfdps_pkg::sfdps_capture_t cap,
    input logic quad
  );
    return quad ? cap.quad_byte : cap.serial_byte;
  endfunction

  // whole-frame match of one instruction
  function automatic logic frame_is(
    input sfdps_pkg::sfdps_capture_t cap,
    input logic quad,
    input logic [7:0] op
  );
    return frame_len_ok(cap, quad) && (frame_byte(cap, quad) == op);
  endfunction

  logic is_entry;
  logic is_release;
  logic entry_byte_long;

  assign is_entry = frame_is(link_cap_r, quad_instruction_mode,
    sfdps_pkg::OP_SLEEP_ENTRY); // R02
  assign is_release = frame_is(link_cap_r, quad_instruction_mode,
    sfdps_pkg::OP_SLEEP_RELEASE); // R08
  // select held low past one byte length; the byte is not checked here
  assign entry_byte_long = !frame_len_ok(link_cap_r, quad_instruction_mode)
    && (link_cap_r.edges > sfdps_pkg::EDGE_CNT_W'(
      quad_instruction_mode ? sfdps_pkg::QUAD_EDGES
                            : sfdps_pkg::SERIAL_EDGES));

  // ------------------------------------------------------------------
  // power sequencing, system clock side
  // ------------------------------------------------------------------

  sfdps_pkg::sfdps_state_t state_r;
  logic [CW-1:0] delay_cnt_r;
  logic delay_done;

  assign delay_done = (delay_cnt_r == '0);

  // state and delay counter; reset always lands in standby
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= sfdps_pkg::SFDPS_STANDBY; // R06 R12
      delay_cnt_r <= '0;
    end else begin
      case (state_r)
        sfdps_pkg::SFDPS_STANDBY: begin
          // a busy device drops the entry and keeps working
          if (frame_end && is_entry && !embedded_op_active) begin // R01 R13
            state_r <= sfdps_pkg::SFDPS_ENTERING; // R03
            delay_cnt_r <= CW'(ENTRY_CYCLES - 1); // R04
          end
        end
        sfdps_pkg::SFDPS_ENTERING: begin
          if (delay_done) begin
            state_r <= sfdps_pkg::SFDPS_SLEEP; // R04
          end else begin
            delay_cnt_r <= delay_cnt_r - 1'b1;
          end
        end
        sfdps_pkg::SFDPS_SLEEP: begin
          // only the release instruction leaves this state
          if (frame_end && is_release) begin // R05
            state_r <= sfdps_pkg::SFDPS_RELEASING;
            delay_cnt_r <= CW'(RELEASE_CYCLES - 1); // R09
          end
        end
        sfdps_pkg::SFDPS_RELEASING: begin
          // frames here break the host's side of the deal; they are
          // dropped and do not stretch the wait
          if (delay_done) begin
            state_r <= sfdps_pkg::SFDPS_STANDBY; // R09
          end else begin
            delay_cnt_r <= delay_cnt_r - 1'b1; // R10
          end
        end
        default: begin
          state_r <= sfdps_pkg::SFDPS_STANDBY;
          delay_cnt_r <= '0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // status levels, registered from the state
  // ------------------------------------------------------------------

  // levels follow the state one cycle later
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      deep_sleep <= 1'b0; // R06
      cmd_accept <= 1'b1;
    end else begin
      deep_sleep <= (state_r == sfdps_pkg::SFDPS_SLEEP);
      cmd_accept <= (state_r == sfdps_pkg::SFDPS_STANDBY); // R05 R09
    end
  end

  // ------------------------------------------------------------------
  // event pulses, one system clock each
  // ------------------------------------------------------------------

  logic in_standby;
  logic asleep_or_moving;

  assign in_standby = (state_r == sfdps_pkg::SFDPS_STANDBY);
  assign asleep_or_moving = !in_standby;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      entry_taken <= 1'b0;
      entry_refused <= 1'b0;
      entry_bad_length <= 1'b0;
      cmd_ignored <= 1'b0;
      release_done <= 1'b0;
    end else begin
      entry_taken <= in_standby && frame_end && is_entry
        && !embedded_op_active; // R01
      entry_refused <= in_standby && frame_end && is_entry
        && embedded_op_active; // R13
      entry_bad_length <= in_standby && frame_end && entry_byte_long
        && (frame_byte(link_cap_r, quad_instruction_mode)
          != sfdps_pkg::OP_SLEEP_RELEASE); // R03
      // any frame not acted on outside standby, including status read
      cmd_ignored <= asleep_or_moving && frame_end
        && !((state_r == sfdps_pkg::SFDPS_SLEEP) && is_release); // R05
      release_done <= (state_r == sfdps_pkg::SFDPS_RELEASING)
        && delay_done; // R09
    end
  end

  // ------------------------------------------------------------------
  // data lines: the release answers nothing, so the block never
  // drives them; held in flops so they are defined from reset
  // ------------------------------------------------------------------

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      quad_data_lines_out <= '0;
      quad_data_lines_oe <= '0;
    end else begin
      quad_data_lines_out <= '0; // R11
      quad_data_lines_oe <= '0; // R11
    end
  end

  // frame_start is kept for observability of early select falls
  logic early_select_r;

  // select falling inside the release wait is a host fault
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      early_select_r <= 1'b0;
    end else begin
      early_select_r <= frame_start
        && (state_r == sfdps_pkg::SFDPS_RELEASING); // R10
    end
  end

endmodule
